//--- rtl/cim_pkg.sv
package cim_pkg;
  localparam int NUM_OBJECTS = 32;
  localparam int IDLE_BITS = 11;
  localparam int DATA_BYTES = 8;
  localparam logic [15:0] BIT_TIMING_RST = 16'h2301;
  localparam logic [3:0] PRESCALER_EXT_RST = 4'h0;
  localparam int DLC_W = 4;
  localparam int ID_W = 29;
  localparam int BIT_DIV_DEFAULT = 40;
  localparam logic [9:0] BUS_OFF_TEC = 10'h100;
  typedef enum logic [1:0] {
    CIM_INIT,
    CIM_SYNC,
    CIM_ACTIVE
  } cim_state_t;
endpackage

//--- rtl/cim_core.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Hold bit sets on software request, reset, or bus-off.
// R2 - While held, no frames move and the transmit pin stays recessive.
// R3 - Error counters keep their values on entering initialisation.
// R4 - Setting the hold bit leaves configuration registers untouched.
// R5 - Bit timing and prescaler writes need hold and change-enable both set.
// R6 - Only software clears hold; then wait eleven recessive bits before transfers.
// R7 - Software programs timing and every object, invalidating unused ones.
// R8 - Object configuration is accepted at any time regardless of hold.
// R9 - Software invalidates an object before changing it, then revalidates.
// R10 - An accepted frame stores identifier, length code and eight data bytes.
// R11 - Masked identifier bits take the received values on storage.
// R12 - Software and bus accesses to an object never see torn data.
// R13 - Fixed transmit objects: software updates data, then sets request and fresh flag.
// R14 - Shared transmit objects are fully reconfigured before each request.
// R15 - Any number of requests are sent in priority order, lowest index first.
// R16 - Updating a pending object before start sends the new content.
// R17 - A matching remote frame raises the object's request when enabled.
// R18 - Remote frames always go out in classical format.
// R19 - Flexible-rate frames with up to eight data bytes are supported.
// R20 - Thirty-two objects, each with its own identifier mask.
// R21 - Flexible-rate enable is writable only with change-enable and hold set.
// R22 - Change-enable without hold keeps bit timing write-protected.
module cim_core #(
  parameter int N_OBJ   = cim_pkg::NUM_OBJECTS,
  parameter int BIT_DIV = cim_pkg::BIT_DIV_DEFAULT
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control bits.
  input  wire logic        hold_set,
  input  wire logic        hold_clear,
  input  wire logic        config_change_enable,
  input  wire logic        timing_wr,
  input  wire logic [15:0] timing_wdata,
  input  wire logic        prescaler_wr,
  input  wire logic [3:0]  prescaler_wdata,
  input  wire logic        fd_wr,
  input  wire logic        flexible_rate_enable_wdata,
  // Object write port.
  input  wire logic        obj_wr,
  input  wire logic [4:0]  obj_idx,
  input  wire logic        obj_valid_wdata,
  input  wire logic        obj_dir_tx,
  input  wire logic        obj_remote_en,
  input  wire logic [28:0] obj_id,
  input  wire logic [28:0] obj_mask,
  input  wire logic [3:0]  obj_dlc,
  input  wire logic [63:0] obj_data,
  input  wire logic        obj_set_req,
  // Object read port.
  input  wire logic [4:0]  rd_idx,
  output logic [28:0]      rd_id,
  output logic [3:0]       rd_dlc,
  output logic [63:0]      rd_data,
  output logic             rd_fresh,
  output logic             rd_req,
  // Frame engine side.
  input  wire logic        rx_bit,
  input  wire logic        rx_frame_valid,
  input  wire logic [28:0] rx_id,
  input  wire logic        rx_remote,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [63:0] rx_data,
  input  wire logic        tx_done,
  input  wire logic        tx_err,
  input  wire logic        rx_err,
  output logic             tx_start,
  output logic [28:0]      tx_id,
  output logic [3:0]       tx_dlc,
  output logic [63:0]      tx_data,
  output logic             tx_remote,
  output logic             tx_fd,
  output logic             tx_pin,
  // Status.
  output logic             hold_q,
  output logic             transfer_on,
  output logic [15:0]      bit_timing_q,
  output logic [3:0]       prescaler_ext_q,
  output logic             flexible_rate_enable_q,
  output logic [7:0]       rx_err_cnt_q,
  output logic [9:0]       tx_err_cnt_q
);

  logic [28:0] id_q    [N_OBJ];
  logic [28:0] mask_q  [N_OBJ];
  logic [3:0]  dlc_q   [N_OBJ];
  logic [63:0] data_q  [N_OBJ];
  logic [N_OBJ-1:0] valid_q, dir_q, remote_en_q, req_q, fresh_q;
  cim_pkg::cim_state_t state_q;
  logic [3:0]  idle_cnt_q;
  logic [15:0] div_q;
  logic        busy_q;
  logic [4:0]  cur_q;
  logic        bit_tick;
  logic        cfg_open;
  logic        bus_off;
  logic        hit_any;
  logic [4:0]  hit_idx;
  logic        pend_any;
  logic [4:0]  pend_idx;
  logic        launch;
  logic        hold_d;

  function automatic logic id_match(input logic [28:0] a, input logic [28:0] b,
                                    input logic [28:0] m);
    id_match = ((a ^ b) & m) == 29'h0000000;
  endfunction

  assign bit_tick = (div_q == 16'(BIT_DIV - 1));
  assign bus_off  = tx_err_cnt_q >= cim_pkg::BUS_OFF_TEC;
  // R5 R22 R21 - Configuration gate.
  assign cfg_open = hold_q && config_change_enable;

  // R20 R10 - Acceptance search, lowest index wins.
  always_comb begin
    hit_any = 1'b0;
    hit_idx = 5'h00;
    for (int i = N_OBJ - 1; i >= 0; i--) begin
      if (valid_q[i] && (dir_q[i] == rx_remote) && id_match(rx_id, id_q[i], mask_q[i])) begin
        hit_any = 1'b1;
        hit_idx = 5'(i);
      end
    end
  end

  // R15 - Priority pick among pending requests.
  always_comb begin
    pend_any = 1'b0;
    pend_idx = 5'h00;
    for (int i = N_OBJ - 1; i >= 0; i--) begin
      if (valid_q[i] && req_q[i]) begin
        pend_any = 1'b1;
        pend_idx = 5'(i);
      end
    end
  end

  assign launch = (state_q == cim_pkg::CIM_ACTIVE) && !busy_q && pend_any && !hold_d;

  // R1 R6 - Next hold value, set wins over clear.
  always_comb begin
    hold_d = hold_q;
    if (hold_set || bus_off) begin
      hold_d = 1'b1;
    end else if (hold_clear) begin
      hold_d = 1'b0;
    end
  end

  // R1 R6 - Hold bit control.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= hold_d;
    end
  end

  // R4 R5 R22 - Timing registers change only by their own writes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_timing_q    <= cim_pkg::BIT_TIMING_RST;
      prescaler_ext_q <= cim_pkg::PRESCALER_EXT_RST;
    end else begin
      if (timing_wr && cfg_open) begin
        bit_timing_q <= timing_wdata;
      end
      if (prescaler_wr && cfg_open) begin
        prescaler_ext_q <= prescaler_wdata;
      end
    end
  end

  // R21 R19 - Flexible-rate enable.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flexible_rate_enable_q <= 1'b0;
    end else if (fd_wr && cfg_open) begin
      flexible_rate_enable_q <= flexible_rate_enable_wdata;
    end
  end

  // R3 - Counters ignore the hold bit.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_err_cnt_q <= 8'h00;
      tx_err_cnt_q <= 10'h000;
    end else begin
      if (rx_err && rx_err_cnt_q != 8'hff) begin
        rx_err_cnt_q <= rx_err_cnt_q + 8'h08;
      end else if (rx_frame_valid && rx_err_cnt_q != 8'h00) begin
        rx_err_cnt_q <= rx_err_cnt_q - 8'h01;
      end
      if (tx_err && !bus_off) begin
        tx_err_cnt_q <= tx_err_cnt_q + 10'h008;
      end else if (tx_done && tx_err_cnt_q != 10'h000) begin
        tx_err_cnt_q <= tx_err_cnt_q - 10'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 16'h0000;
    end else if (bit_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // R6 - Bus idle search after hold is released.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= cim_pkg::CIM_INIT;
      idle_cnt_q <= 4'h0;
    end else if (hold_q) begin
      state_q    <= cim_pkg::CIM_INIT;
      idle_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        cim_pkg::CIM_INIT: begin
          state_q    <= cim_pkg::CIM_SYNC;
          idle_cnt_q <= 4'h0;
        end
        cim_pkg::CIM_SYNC: begin
          if (bit_tick) begin
            if (!rx_bit) begin
              idle_cnt_q <= 4'h0;
            end else if (idle_cnt_q == 4'(cim_pkg::IDLE_BITS - 1)) begin
              state_q <= cim_pkg::CIM_ACTIVE;
            end else begin
              idle_cnt_q <= idle_cnt_q + 4'h1;
            end
          end
        end
        cim_pkg::CIM_ACTIVE: state_q <= cim_pkg::CIM_ACTIVE;
        default: state_q <= cim_pkg::CIM_INIT;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      transfer_on <= 1'b0;
    end else begin
      transfer_on <= (state_q == cim_pkg::CIM_ACTIVE) && !hold_d;
    end
  end

  // R8 R10 R11 R12 R16 R17 - Object store; CPU write takes precedence per object.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q     <= '0;
      dir_q       <= '0;
      remote_en_q <= '0;
      req_q       <= '0;
      fresh_q     <= '0;
    end else begin
      if (launch) begin
        req_q[pend_idx] <= 1'b0;
      end
      if (tx_done && busy_q) begin
        fresh_q[cur_q] <= 1'b0;
      end
      if (rx_frame_valid && transfer_on && hit_any && !(obj_wr && obj_idx == hit_idx)) begin
        if (rx_remote) begin
          // R17 - Remote frame answer.
          if (remote_en_q[hit_idx]) begin
            req_q[hit_idx] <= 1'b1;
          end
        end else begin
          // R11 - Masked bits take received values.
          id_q[hit_idx]    <= rx_id;
          dlc_q[hit_idx]   <= rx_dlc;
          data_q[hit_idx]  <= rx_data;
          fresh_q[hit_idx] <= 1'b1;
        end
      end
      if (obj_wr) begin
        valid_q[obj_idx]     <= obj_valid_wdata;
        dir_q[obj_idx]       <= obj_dir_tx;
        remote_en_q[obj_idx] <= obj_remote_en;
        id_q[obj_idx]        <= obj_id;
        mask_q[obj_idx]      <= obj_mask;
        dlc_q[obj_idx]       <= obj_dlc;
        data_q[obj_idx]      <= obj_data;
        req_q[obj_idx]       <= obj_set_req;
        fresh_q[obj_idx]     <= obj_set_req;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_id    <= 29'h0000000;
      rd_dlc   <= 4'h0;
      rd_data  <= 64'h0;
      rd_fresh <= 1'b0;
      rd_req   <= 1'b0;
    end else begin
      rd_id    <= id_q[rd_idx];
      rd_dlc   <= dlc_q[rd_idx];
      rd_data  <= data_q[rd_idx];
      rd_fresh <= fresh_q[rd_idx];
      rd_req   <= req_q[rd_idx];
    end
  end

  // R15 R16 R18 R2 - Transmit launch with content taken at start.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q    <= 1'b0;
      cur_q     <= 5'h00;
      tx_start  <= 1'b0;
      tx_id     <= 29'h0000000;
      tx_dlc    <= 4'h0;
      tx_data   <= 64'h0;
      tx_remote <= 1'b0;
      tx_fd     <= 1'b0;
    end else begin
      tx_start <= launch;
      if (hold_q || tx_done || tx_err) begin
        busy_q <= 1'b0;
      end else if (launch) begin
        busy_q    <= 1'b1;
        cur_q     <= pend_idx;
        tx_id     <= id_q[pend_idx];
        tx_dlc    <= dlc_q[pend_idx];
        tx_data   <= data_q[pend_idx];
        tx_remote <= !dir_q[pend_idx];
        tx_fd     <= flexible_rate_enable_q && dir_q[pend_idx];
      end
    end
  end

  // R2 - Transmit pin recessive while held.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= hold_d ? 1'b1 : (busy_q ? tx_id[28] : 1'b1);
    end
  end

endmodule
`default_nettype wire

//--- verif/cim_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cim_bus_model #(
  parameter int DONE_LAT = 6
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Controller side.
  input  wire logic tx_start,
  input  wire logic tx_pin,
  input  wire logic drive_dom,
  output logic      rx_bit,
  output logic      tx_done,
  output logic      tx_err
);
  int cnt_q;
  assign rx_bit = tx_pin & ~drive_dom;
  assign tx_err = 1'b0;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (cnt_q == 1);
      if (tx_start) begin
        cnt_q <= DONE_LAT;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/cim_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cim_core_checker #(
  parameter int BIT_DIV = 40
) (
  input wire logic        clk, sys_rst, hold_set, hold_clear, config_change_enable,
  input wire logic        timing_wr, prescaler_wr, fd_wr, flexible_rate_enable_wdata,
  input wire logic        rx_bit, tx_err, rx_err, tx_done, tx_start, tx_remote, tx_fd,
  input wire logic        tx_pin, hold_q, transfer_on, flexible_rate_enable_q,
  input wire logic [15:0] timing_wdata, bit_timing_q,
  input wire logic [3:0]  prescaler_wdata, prescaler_ext_q,
  input wire logic [7:0]  rx_err_cnt_q,
  input wire logic [9:0]  tx_err_cnt_q
);
  int rec_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst || !rx_bit) begin
      rec_q <= 0;
    end else if (rec_q < 100000) begin
      rec_q <= rec_q + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_held_bus_quiet: assert property (hold_q |-> tx_pin && !tx_start && !transfer_on)
    else $error("bus activity while held");
  a_hold_set_taken: assert property (hold_set |=> hold_q)
    else $error("hold not set");
  a_hold_keeps_errors: assert property (hold_set && !tx_err && !rx_err && !tx_done |=>
    $stable(rx_err_cnt_q) && $stable(tx_err_cnt_q)) else $error("error counts changed");
  a_hold_keeps_cfg: assert property (hold_set && !timing_wr && !prescaler_wr && !fd_wr |=>
    $stable(bit_timing_q) && $stable(prescaler_ext_q) && $stable(flexible_rate_enable_q))
    else $error("config changed by hold");
  a_timing_locked: assert property (!(hold_q && config_change_enable && timing_wr) |=>
    $stable(bit_timing_q)) else $error("timing changed while locked");
  a_timing_write: assert property (hold_q && config_change_enable && timing_wr |=>
    bit_timing_q == $past(timing_wdata)) else $error("timing write lost");
  a_presc_locked: assert property (!(hold_q && config_change_enable && prescaler_wr) |=>
    $stable(prescaler_ext_q)) else $error("prescaler changed while locked");
  a_flex_locked: assert property (!(hold_q && config_change_enable && fd_wr) |=>
    $stable(flexible_rate_enable_q)) else $error("flex enable changed while locked");
  a_clear_by_cpu: assert property ($fell(hold_q) |-> $past(hold_clear) && !$past(hold_set))
    else $error("hold cleared without request");
  a_sync_idle: assert property ($rose(transfer_on) |-> rec_q >= 10 * BIT_DIV + 1)
    else $error("joined bus before idle");
  a_remote_classic: assert property (tx_start && tx_remote |-> !tx_fd)
    else $error("remote frame in flexible format");
endmodule
bind cim_core cim_core_checker #(.BIT_DIV(BIT_DIV)) u_chk (.clk, .sys_rst, .hold_set,
  .hold_clear, .config_change_enable, .timing_wr, .prescaler_wr, .fd_wr,
  .flexible_rate_enable_wdata, .rx_bit, .tx_err, .rx_err, .tx_done, .tx_start, .tx_remote,
  .tx_fd, .tx_pin, .hold_q, .transfer_on, .flexible_rate_enable_q, .timing_wdata,
  .bit_timing_q, .prescaler_wdata, .prescaler_ext_q, .rx_err_cnt_q, .tx_err_cnt_q);
`default_nettype wire

//--- verif/tb_cim_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cim_core;
  logic        clk, sys_rst, hold_set, hold_clear, config_change_enable, timing_wr, fd_wr;
  logic        prescaler_wr, flexible_rate_enable_wdata, obj_wr, obj_valid_wdata, obj_dir_tx;
  logic        obj_remote_en, obj_set_req, rx_frame_valid, rx_remote, rx_err, drive_dom;
  logic        rx_bit, tx_done, tx_err, tx_start, tx_remote, tx_fd, tx_pin, hold_q;
  logic        transfer_on, flexible_rate_enable_q, rd_fresh, rd_req;
  logic [15:0] timing_wdata, bit_timing_q;
  logic [3:0]  prescaler_wdata, prescaler_ext_q, obj_dlc, rx_dlc, rd_dlc, tx_dlc;
  logic [4:0]  obj_idx, rd_idx;
  logic [28:0] obj_id, obj_mask, rx_id, rd_id, tx_id, sid;
  logic [63:0] obj_data, rx_data, rd_data, tx_data, sdt;
  logic [7:0]  rx_err_cnt_q;
  logic [9:0]  tx_err_cnt_q;
  int          fail_count, compares, cyc;
  always #12.5 clk = ~clk;
  cim_core #(.BIT_DIV(2)) dut (.clk, .sys_rst, .hold_set, .hold_clear, .config_change_enable,
    .timing_wr, .timing_wdata, .prescaler_wr, .prescaler_wdata, .fd_wr,
    .flexible_rate_enable_wdata, .obj_wr, .obj_idx, .obj_valid_wdata, .obj_dir_tx,
    .obj_remote_en, .obj_id, .obj_mask, .obj_dlc, .obj_data, .obj_set_req, .rd_idx, .rd_id,
    .rd_dlc, .rd_data, .rd_fresh, .rd_req, .rx_bit, .rx_frame_valid, .rx_id, .rx_remote,
    .rx_dlc, .rx_data, .tx_done, .tx_err, .rx_err, .tx_start, .tx_id, .tx_dlc, .tx_data,
    .tx_remote, .tx_fd, .tx_pin, .hold_q, .transfer_on, .bit_timing_q, .prescaler_ext_q,
    .flexible_rate_enable_q, .rx_err_cnt_q, .tx_err_cnt_q);
  cim_bus_model model (.clk, .sys_rst, .tx_start, .tx_pin, .drive_dom, .rx_bit, .tx_done,
    .tx_err);
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wobj(input logic [4:0] i, input logic d, input logic re,
                      input logic [28:0] id, input logic [28:0] m, input logic [63:0] dt,
                      input logic rq);
    @(posedge clk);
    {obj_wr, obj_idx, obj_valid_wdata, obj_dir_tx, obj_remote_en, obj_id, obj_mask, obj_dlc,
     obj_data, obj_set_req} <= {1'b1, i, 1'b1, d, re, id, m, 4'h8, dt, rq};
    @(posedge clk);
    obj_wr <= 1'b0;
  endtask
  task automatic inval(input logic [4:0] i);
    @(posedge clk);
    {obj_wr, obj_idx, obj_valid_wdata, obj_set_req} <= {1'b1, i, 1'b0, 1'b0};
    @(posedge clk);
    obj_wr <= 1'b0;
  endtask
  task automatic rxf(input logic [28:0] id, input logic rem, input logic [63:0] dt);
    @(posedge clk);
    {rx_frame_valid, rx_id, rx_remote, rx_dlc, rx_data} <= {1'b1, id, rem, 4'h8, dt};
    @(posedge clk);
    rx_frame_valid <= 1'b0;
  endtask
  task automatic hold(input logic s);
    @(posedge clk);
    {hold_set, hold_clear} <= {s, ~s};
    @(posedge clk);
    {hold_set, hold_clear} <= 2'b00;
  endtask
  task automatic cfg(input logic c, input logic [15:0] t, input logic [3:0] p, input logic f);
    @(posedge clk);
    config_change_enable <= c;
    @(posedge clk);
    {timing_wr, timing_wdata, prescaler_wr, prescaler_wdata, fd_wr,
     flexible_rate_enable_wdata} <= {1'b1, t, 1'b1, p, 1'b1, f};
    @(posedge clk);
    {timing_wr, prescaler_wr, fd_wr} <= 3'b000;
    tick(1);
  endtask
  task automatic wait_tx();
    #1;
    for (int k = 0; k < 300 && tx_start !== 1'b1; k++) tick(1);
    chk("tx_start", tx_start, 1);
    sid = tx_id;
    sdt = tx_data;
  endtask
  task automatic t_cfg();
    chk("hold_q", hold_q, 1);
    chk("tx_pin", tx_pin, 1);
    chk("bit_timing", bit_timing_q, 16'h2301);
    cfg(1'b0, 16'h1234, 4'h5, 1'b1);
    chk("bit_timing", bit_timing_q, 16'h2301);
    chk("prescaler", prescaler_ext_q, 4'h0);
    chk("flex_en", flexible_rate_enable_q, 0);
    cfg(1'b1, 16'h1234, 4'h5, 1'b1);
    chk("bit_timing", bit_timing_q, 16'h1234);
    chk("prescaler", prescaler_ext_q, 4'h5);
    chk("flex_en", flexible_rate_enable_q, 1);
  endtask
  task automatic t_tx();
    int n;
    // Objects set up while held, request and fresh flag together.
    wobj(5'd3, 1'b1, 1'b0, 29'h0a3, '1, 64'ha, 1'b1);
    wobj(5'd1, 1'b1, 1'b0, 29'h011, '1, 64'hb, 1'b1);
    hold(1'b0);
    repeat (8) @(posedge clk);
    drive_dom <= 1'b1;
    repeat (4) @(posedge clk);
    drive_dom <= 1'b0;
    n = 0;
    for (n = 0; n < 200 && transfer_on !== 1'b1; n++) tick(1);
    chk("sync_wait", n >= 22 && n <= 28, 1);
    wait_tx();
    chk("first_id", sid, 29'h011);
    chk("first_dlc", tx_dlc, 4'h8);
    // Invalidate, then fully rewrite the pending object.
    inval(5'd3);
    wobj(5'd3, 1'b1, 1'b0, 29'h0a3, '1, 64'hc, 1'b1);
    wait_tx();
    chk("second_id", sid, 29'h0a3);
    chk("second_data", sdt, 64'hc);
  endtask
  task automatic t_rx();
    wobj(5'd5, 1'b0, 1'b0, 29'h155, 29'h1ffffff0, 64'h0, 1'b0);
    rxf(29'h15a, 1'b0, 64'h1122334455667788);
    rd_idx <= 5'd5;
    tick(2);
    chk("rd_id", rd_id, 29'h15a);
    chk("rd_dlc", rd_dlc, 4'h8);
    chk("rd_data", rd_data, 64'h1122334455667788);
    chk("rd_fresh", rd_fresh, 1);
    wobj(5'd7, 1'b1, 1'b1, 29'h077, '1, 64'hd, 1'b0);
    rxf(29'h077, 1'b1, 64'h0);
    wait_tx();
    chk("remote_id", sid, 29'h077);
    chk("answer_remote", tx_remote, 0);
    chk("answer_fd", tx_fd, 1);
    wobj(5'd9, 1'b0, 1'b0, 29'h099, '1, 64'h0, 1'b1);
    wait_tx();
    chk("remote_out", tx_remote, 1);
    chk("remote_fd", tx_fd, 0);
  endtask
  task automatic t_hold();
    logic [17:0] e;
    int          n;
    tick(10);
    e = {rx_err_cnt_q, tx_err_cnt_q};
    hold(1'b1);
    wobj(5'd1, 1'b1, 1'b0, 29'h011, '1, 64'hb, 1'b1);
    n = 0;
    repeat (30) begin
      tick(1);
      n += (tx_start === 1'b1);
    end
    chk("hold_q", hold_q, 1);
    chk("held_starts", n, 0);
    chk("tx_pin", tx_pin, 1);
    chk("err_counts", {rx_err_cnt_q, tx_err_cnt_q}, e);
    chk("bit_timing", bit_timing_q, 16'h1234);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    clk = 0;
    sys_rst = 1;
    {hold_set, hold_clear, config_change_enable, timing_wr, fd_wr, prescaler_wr,
     flexible_rate_enable_wdata, obj_wr, obj_valid_wdata, obj_dir_tx, obj_remote_en,
     obj_set_req, rx_frame_valid, rx_remote, rx_err, drive_dom} = '0;
    {timing_wdata, prescaler_wdata, obj_dlc, rx_dlc, obj_idx, rd_idx} = '0;
    {obj_id, obj_mask, rx_id, obj_data, rx_data} = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    t_cfg();
    t_tx();
    t_rx();
    t_hold();
    results();
  end
endmodule
`default_nettype wire
